// *** dv/svl_cpu_model.sv ***
// Behavioural CPU core that accepts interrupt requests and fetches vectors.
// Assumes the block's registered outputs and the bench driving at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module svl_cpu_model (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        cpu_irq_q,
  input  wire logic        sys_reset_q,
  input  wire logic        accept_en,
  input  wire logic [3:0]  stall,
  input  wire logic [4:0]  vec_num_q,
  input  wire logic [15:0] vec_addr_q,
  output logic             vec_fetch,
  output logic [4:0]       got_num,
  output logic [15:0]      got_addr,
  output logic             got
);
  logic       mask_q;  // Global mask, set on acceptance
  logic [3:0] wait_q;  // Cycles spent finishing the current instruction
  logic       pend_q;  // Fetch issued, vector due after the next edge

  initial begin
    vec_fetch = 1'b0;
    got       = 1'b0;
    got_num   = 5'h00;
    got_addr  = 16'h0000;
    mask_q    = 1'b0;
    wait_q    = 4'h0;
    pend_q    = 1'b0;
  end

  // Acceptance sequence; the stall lets one fetch be prompt and another slow
  always @(negedge sys_clk) begin
    vec_fetch <= 1'b0;
    if (rst || sys_reset_q) begin
      // A reset throws away any half-done acceptance
      mask_q <= 1'b0;
      wait_q <= 4'h0;
      pend_q <= 1'b0;
      got    <= 1'b0;
    end else if (pend_q) begin
      // Vector settled one edge after the fetch pulse
      got_num  <= vec_num_q;
      got_addr <= vec_addr_q;
      got      <= 1'b1;
      pend_q   <= 1'b0;
    end else if (!accept_en) begin
      // Return from service: unmask and forget the last vector
      mask_q <= 1'b0;
      wait_q <= 4'h0;
      got    <= 1'b0;
    end else if (cpu_irq_q && !mask_q) begin
      if (wait_q == stall) begin
        // Registers stacked, mask set, then the vector is fetched
        vec_fetch <= 1'b1;
        mask_q    <= 1'b1;
        pend_q    <= 1'b1;
      end else begin
        wait_q <= wait_q + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// *** dv/system_vector_lvd_control_tb_top.sv ***
// Self-checking bench for the vector, low-voltage and clock-out block.
// Assumes the CPU model file is compiled first; only ce is tied high.
`timescale 1ns/1ps
`default_nettype none
module system_vector_lvd_control_tb_top;
  logic sys_clk, rst, por_in, lvd_below_low, lvd_below_high, lvw_warn_in, lvw_flag_clr;
  logic vec_fetch, port_out, port_dir_out, cpu_irq_q, sys_reset_q, lvw_flag_q, lvd_active_q;
  logic shared_port_pin_o_q, shared_port_pin_oe_n_q, accept_en, got;
  svl_pkg::svl_rst_cause_t rst_cause;
  svl_pkg::svl_lvd_ctrl_t  lvd_ctrl;
  svl_pkg::svl_stop_t      stop_req, stop_mode_q;
  logic [31:0]             src_flag, src_int_enable;
  logic [2:0]              clkout_select;
  logic [4:0]              vec_num_q, got_num;
  logic [15:0]             vec_addr_q, got_addr;
  logic [7:0]              reset_source_register_q;
  logic [3:0]              stall;
  int                      mismatches, tests_run;

  svl_top DUT (.sys_clk(sys_clk), .rst(rst), .ce(1'b1), .por_in(por_in), .lvd_below_low(lvd_below_low),
    .lvd_below_high(lvd_below_high), .lvw_warn_in(lvw_warn_in), .rst_cause(rst_cause), .lvd_ctrl(lvd_ctrl),
    .lvw_flag_clr(lvw_flag_clr), .src_flag(src_flag), .src_int_enable(src_int_enable), .vec_fetch(vec_fetch),
    .stop_req(stop_req), .clkout_select(clkout_select), .port_out(port_out), .port_dir_out(port_dir_out),
    .cpu_irq_q(cpu_irq_q), .vec_num_q(vec_num_q), .vec_addr_q(vec_addr_q), .sys_reset_q(sys_reset_q),
    .reset_source_register_q(reset_source_register_q), .lvw_flag_q(lvw_flag_q), .lvd_active_q(lvd_active_q),
    .stop_mode_q(stop_mode_q), .shared_port_pin_o_q(shared_port_pin_o_q),
    .shared_port_pin_oe_n_q(shared_port_pin_oe_n_q));

  svl_cpu_model cpu (.sys_clk(sys_clk), .rst(rst), .cpu_irq_q(cpu_irq_q), .sys_reset_q(sys_reset_q),
    .accept_en(accept_en), .stall(stall), .vec_num_q(vec_num_q), .vec_addr_q(vec_addr_q),
    .vec_fetch(vec_fetch), .got_num(got_num), .got_addr(got_addr), .got(got));

  // 100 MHz bus clock
  always #5 sys_clk = ~sys_clk;

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Selects the output a bounded wait watches
  function automatic logic pick(input int id);
    case (id)
      0: pick = sys_reset_q;
      1: pick = got;
      2: pick = lvw_flag_q;
      default: pick = shared_port_pin_o_q;
    endcase
  endfunction

  // Bounded wait at falling edges; running out ends the run
  task automatic wait_lvl(input int id, input logic v, input int lim);
    int k;
    k = 0;
    while (pick(id) !== v && k < lim) begin
      @(negedge sys_clk);
      k++;
    end
    if (pick(id) !== v) begin
      mismatches++;
      $display("MISMATCH at %0t: wait on output %0d timed out", $time, id);
      final_report();
    end
  endtask

  // Let the CPU model take one request and compare its vector with FFFE-2n
  task automatic service(input int n);
    accept_en = 1'b1;
    wait_lvl(1, 1'b1, 40);
    check(got_num, n);
    check(got_addr, 16'hfffe - 16'(2 * n));
    accept_en = 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask

  // Part stays held until both the power-on and low-threshold conditions clear
  task automatic t_power_on;
    check(sys_reset_q, 1'b1);
    check(reset_source_register_q, 8'h82);
    por_in = 1'b0;
    repeat (10) @(negedge sys_clk);
    check(sys_reset_q, 1'b1);
    lvd_below_low = 1'b0;
    wait_lvl(0, 1'b0, 10);
    check(reset_source_register_q, 8'h82);
  endtask

  // Single sources at prompt and slow acceptance, then lower number beats higher
  task automatic t_vectors;
    int v[5] = '{1, 2, 4, 12, 31};
    src_int_enable = '1;
    for (int i = 0; i < 5; i++) begin
      src_flag = 32'h1 << v[i];
      stall = 4'(i * 3);
      service(v[i]);
    end
    src_flag = 32'h8000_1004;
    service(2);
    src_int_enable[2] = 1'b0;
    service(12);
    src_int_enable = '0;
    repeat (3) @(negedge sys_clk);
    check(cpu_irq_q, 1'b0);
    src_flag = '0;
  endtask

  // Warning flag needs the detector; the request needs the warning enable
  task automatic t_warning;
    lvd_ctrl = '0;
    lvw_warn_in = 1'b1;
    repeat (8) @(negedge sys_clk);
    check(lvw_flag_q, 1'b0);
    check(lvd_active_q, 1'b0);
    lvd_ctrl.lvd_enable = 1'b1;
    wait_lvl(2, 1'b1, 8);
    check(lvd_active_q, 1'b1);
    repeat (3) @(negedge sys_clk);
    check(cpu_irq_q, 1'b0);
    lvd_ctrl.lvw_int_enable = 1'b1;
    service(3);
    check(got_addr, 16'hfff8);
    lvw_warn_in = 1'b0;
    repeat (4) @(negedge sys_clk);
    lvw_flag_clr = 1'b1;
    @(negedge sys_clk);
    lvw_flag_clr = 1'b0;
    @(negedge sys_clk);
    check(lvw_flag_q, 1'b0);
    lvd_ctrl.lvw_int_enable = 1'b0;
  endtask

  // Granted stop mode and detector state for each enable combination except both clear
  task automatic t_stop;
    logic [3:0] se = 4'b1011;
    logic [3:0] ee = 4'b0111;
    svl_pkg::svl_stop_t rq[4] = '{svl_pkg::SVL_STOP_SHALLOW, svl_pkg::SVL_STOP_DEEP,
                                  svl_pkg::SVL_STOP_DEEP, svl_pkg::SVL_STOP_DEEP};
    svl_pkg::svl_stop_t ex[4] = '{svl_pkg::SVL_STOP_SHALLOW, svl_pkg::SVL_STOP_SHALLOW,
                                  svl_pkg::SVL_STOP_DEEP, svl_pkg::SVL_STOP_DEEP};
    for (int i = 0; i < 4; i++) begin
      lvd_ctrl.lvd_stop_enable = se[i];
      lvd_ctrl.lvd_enable = ee[i];
      stop_req = rq[i];
      repeat (3) @(negedge sys_clk);
      check(stop_mode_q, ex[i]);
      check(lvd_active_q, se[i] & ee[i]);
      stop_req = svl_pkg::SVL_RUN;
      repeat (3) @(negedge sys_clk);
    end
    lvd_ctrl = '0;
  endtask

  // Every non-power cause lands on the reset vector; each but the debugger-forced one marks its own bit
  task automatic t_causes;
    logic [7:0] ex[6] = '{8'h20, 8'h04, 8'h40, 8'h10, 8'h08, 8'h00};
    for (int i = 0; i < 6; i++) begin
      rst_cause = svl_pkg::svl_rst_cause_t'(6'h20 >> i);
      @(negedge sys_clk);
      rst_cause = '0;
      wait_lvl(0, 1'b1, 5);
      check(vec_num_q, 5'h00);
      check(vec_addr_q, 16'hfffe);
      wait_lvl(0, 1'b0, 10);
      check(reset_source_register_q, ex[i]);
    end
  endtask

  // Trip needs reset enable and the selected comparator; hold lasts while low
  task automatic t_lvd_reset;
    lvd_ctrl.lvd_enable = 1'b1;
    lvd_ctrl.lvd_threshold_select = 1'b1;
    lvd_below_high = 1'b1;
    repeat (8) @(negedge sys_clk);
    check(sys_reset_q, 1'b0);
    lvd_ctrl.lvd_reset_enable = 1'b1;
    lvd_ctrl.lvd_threshold_select = 1'b0;
    repeat (8) @(negedge sys_clk);
    check(sys_reset_q, 1'b0);
    lvd_ctrl.lvd_threshold_select = 1'b1;
    wait_lvl(0, 1'b1, 8);
    repeat (12) @(negedge sys_clk);
    check(sys_reset_q, 1'b1);
    lvd_below_high = 1'b0;
    wait_lvl(0, 1'b0, 10);
    check(reset_source_register_q, 8'h02);
    lvd_ctrl = '0;
  endtask

  // Port passthrough at select zero, then the period of each divided clock
  task automatic t_clkout;
    int n;
    logic lo;
    port_out = 1'b1;
    port_dir_out = 1'b1;
    repeat (3) @(negedge sys_clk);
    check(shared_port_pin_o_q, 1'b1);
    check(shared_port_pin_oe_n_q, 1'b0);
    port_dir_out = 1'b0;
    port_out = 1'b0;
    repeat (3) @(negedge sys_clk);
    check(shared_port_pin_oe_n_q, 1'b1);
    for (int s = 1; s < 8; s++) begin
      clkout_select = 3'(s);
      repeat (3) @(negedge sys_clk);
      check(shared_port_pin_oe_n_q, 1'b0);
      wait_lvl(3, 1'b0, 300);
      wait_lvl(3, 1'b1, 300);
      // A period ends at the first high that follows a low
      n = 0;
      lo = 1'b0;
      do begin
        @(negedge sys_clk);
        n++;
        if (shared_port_pin_o_q === 1'b0) begin
          lo = 1'b1;
        end
      end while (!(lo && shared_port_pin_o_q === 1'b1) && n < 300);
      check(n, 1 << s);
    end
    clkout_select = 3'h0;
  endtask

  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    por_in = 1'b1;
    lvd_below_low = 1'b1;
    lvd_below_high = 1'b0;
    lvw_warn_in = 1'b0;
    lvw_flag_clr = 1'b0;
    rst_cause = '0;
    lvd_ctrl = '0;
    src_flag = '0;
    src_int_enable = '0;
    stop_req = svl_pkg::SVL_RUN;
    clkout_select = 3'h0;
    port_out = 1'b0;
    port_dir_out = 1'b0;
    accept_en = 1'b0;
    stall = 4'h0;
    mismatches = 0;
    tests_run = 0;
    repeat (20) @(negedge sys_clk);
    rst = 1'b0;
    t_power_on();
    t_vectors();
    t_warning();
    t_stop();
    t_causes();
    t_lvd_reset();
    t_clkout();
    final_report();
  end
endmodule
`default_nettype wire

// *** hw/svl_clkdiv.sv ***
// Divided clock generator for the shared port pin.
// Assumes sel is a stable configuration level on the same clock.
`timescale 1ns/1ps
`default_nettype none
module svl_clkdiv #(
  parameter int SEL_W = svl_pkg::CLKOUT_SEL_W,
  parameter int CNT_W = svl_pkg::CLKOUT_CNT_W
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic [SEL_W-1:0] sel,
  output logic                  clk_div
);

  logic [CNT_W-1:0] cnt_q;                               // Free-running divider count
  logic [SEL_W-1:0] sel_q;                               // Last seen select, restarts on change

  // Ratio is 2**sel: bit sel-1 of the counter toggles at bus/2**sel
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_q <= '0;
      sel_q <= '0;
    end else if (ce) begin
      sel_q <= sel;
      if (sel != sel_q) begin                            // Restart so no runt phase lingers
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  // Output tap; select 0 yields low (pin handed back to port)
  always_comb begin
    if (sel == '0) begin
      clk_div = 1'b0;
    end else begin
      clk_div = cnt_q[sel - 1'b1];
    end
  end

endmodule
`default_nettype wire

// *** hw/svl_pkg.sv ***
// Shared constants and carrier types for the system vector / low-voltage / clock-out block.
// Assumes a single 100 MHz bus clock and a synchronous active-high reset.
`default_nettype none
package svl_pkg;

  // Vector numbering and addressing
  localparam int          NUM_VECTORS   = 32;            // Vector numbers 0..31
  localparam logic [15:0] VEC_TOP_ADDR  = 16'hfffe;      // Address of vector 0 high byte
  localparam logic [4:0]  VEC_RESET     = 5'h00;         // Reset vector number
  localparam logic [4:0]  VEC_SWI       = 5'h01;         // Software interrupt vector number
  localparam logic [4:0]  VEC_EXT_PIN   = 5'h02;         // External pin vector number
  localparam logic [4:0]  VEC_LVW       = 5'h03;         // Low-voltage warning vector number
  localparam logic [4:0]  VEC_PLL       = 5'h04;         // PLL unlock vector number

  // Reset-source register bit positions
  localparam int RSR_POR  = 7;                           // Power-on
  localparam int RSR_PIN  = 6;                           // External pin
  localparam int RSR_WDOG = 5;                           // Watchdog
  localparam int RSR_OPC  = 4;                           // Illegal opcode
  localparam int RSR_ADR  = 3;                           // Illegal address
  localparam int RSR_LOC  = 2;                           // Loss of clock
  localparam int RSR_LVD  = 1;                           // Low voltage
  localparam logic [7:0] RSR_RESET_VAL = 8'h82;          // Value after power-on

  // Clock-out divider
  localparam int CLKOUT_SEL_W = 3;                       // Width of clkout_select
  localparam int CLKOUT_CNT_W = 8;                       // Divider counter width

  // Reset causes other than power and low voltage
  typedef struct packed {
    logic watchdog;                                      // Watchdog timeout
    logic clock_loss;                                    // Loss of clock
    logic ext_pin;                                       // External reset pin
    logic bad_opcode;                                    // Illegal opcode
    logic bad_address;                                   // Illegal address
    logic debugger_forced_reset;                         // Debugger-forced reset
  } svl_rst_cause_t;

  // Low-voltage control bits
  typedef struct packed {
    logic lvd_enable;                                    // Detector on
    logic lvd_stop_enable;                               // Keep detector in stop
    logic lvd_reset_enable;                              // Detection resets the part
    logic lvd_threshold_select;                          // Chooses detection threshold
    logic lvw_int_enable;                                // Warning interrupt enable
  } svl_lvd_ctrl_t;

  // Stop-mode requests and grants
  typedef enum logic [1:0] {
    SVL_RUN,
    SVL_STOP_SHALLOW,
    SVL_STOP_DEEP
  } svl_stop_t;

endpackage
`default_nettype wire

// *** hw/svl_top.sv ***
// System vector ranking, low-voltage control and clock-out for a small microcontroller.
// Assumes all inputs except the analog comparators and power-on input come from bus-clock logic.
//
// What this block does
// - Lower vector number wins; address FFFE-2n.
// - Reset is vector 0, highest, at FFFE/FFFF.
// - Eight reset causes share the reset vector.
// - Flag requests only while its enable is 1.
// - Detector active only while lvd_enable set.
// - Stop disables detector unless lvd_stop_enable.
// - Both set: deep stop becomes shallow stop.
// - After power-on, hold reset until supply good.
// - Power-on sets power-on and low-voltage bits.
// - Low voltage resets only with lvd_reset_enable.
// - Low-voltage reset holds until supply recovers.
// - Warning with enable sets flag, vector 3.
// - Select zero: clock off, pin to port.
// - Select nonzero: pin drives divided clock.
// - Select value picks the division ratio.
`timescale 1ns/1ps
`default_nettype none
module svl_top #(
  parameter int NVEC  = svl_pkg::NUM_VECTORS,
  parameter int SEL_W = svl_pkg::CLKOUT_SEL_W
) (
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  input  wire logic                   ce,
  input  wire logic                   por_in,
  input  wire logic                   lvd_below_low,
  input  wire logic                   lvd_below_high,
  input  wire logic                   lvw_warn_in,
  input  wire svl_pkg::svl_rst_cause_t rst_cause,
  input  wire svl_pkg::svl_lvd_ctrl_t  lvd_ctrl,
  input  wire logic                   lvw_flag_clr,
  input  wire logic [NVEC-1:0]        src_flag,
  input  wire logic [NVEC-1:0]        src_int_enable,
  input  wire logic                   vec_fetch,
  input  wire svl_pkg::svl_stop_t      stop_req,
  input  wire logic [SEL_W-1:0]       clkout_select,
  input  wire logic                   port_out,
  input  wire logic                   port_dir_out,
  output logic                        cpu_irq_q,
  output logic [4:0]                  vec_num_q,
  output logic [15:0]                 vec_addr_q,
  output logic                        sys_reset_q,
  output logic [7:0]                  reset_source_register_q,
  output logic                        lvw_flag_q,
  output logic                        lvd_active_q,
  output svl_pkg::svl_stop_t           stop_mode_q,
  output logic                        shared_port_pin_o_q,
  output logic                        shared_port_pin_oe_n_q
);

  // Two-stage synchronisers for analog comparator and power inputs
  logic [3:0] sync1_q;                                   // First stage, read only by second
  logic [3:0] sync2_q;                                   // Second stage, safe to use
  logic       por_s;                                     // Synced power-on
  logic       below_low_s;                               // Synced below low threshold
  logic       below_high_s;                              // Synced below high threshold
  logic       warn_s;                                    // Synced warning comparator

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      // Start as power bad and supply low, so the hold cannot release early
      sync1_q <= 4'hc;
      sync2_q <= 4'hc;
    end else if (ce) begin
      sync1_q <= {por_in, lvd_below_low, lvd_below_high, lvw_warn_in};
      sync2_q <= sync1_q;
    end
  end

  assign por_s        = sync2_q[3];
  assign below_low_s  = sync2_q[2];
  assign below_high_s = sync2_q[1];
  assign warn_s       = sync2_q[0];

  // Stop-mode grant: deep request degrades to shallow when detector must stay on
  svl_pkg::svl_stop_t stop_d;                            // Granted stop mode
  always_comb begin
    stop_d = stop_req;
    if (stop_req == svl_pkg::SVL_STOP_DEEP && lvd_ctrl.lvd_enable && lvd_ctrl.lvd_stop_enable) begin
      stop_d = svl_pkg::SVL_STOP_SHALLOW;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stop_mode_q <= svl_pkg::SVL_RUN;
    end else if (ce) begin
      stop_mode_q <= stop_d;
    end
  end

  // Detector active state; a stop without stop-enable switches it off
  logic lvd_active_d;                                    // Next detector state
  always_comb begin
    lvd_active_d = lvd_ctrl.lvd_enable;
    if (stop_d != svl_pkg::SVL_RUN && !lvd_ctrl.lvd_stop_enable) begin
      lvd_active_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lvd_active_q <= 1'b0;
    end else if (ce) begin
      lvd_active_q <= lvd_active_d;
    end
  end

  // Threshold select chooses which comparator output counts as low voltage
  logic lvd_low_now;                                     // Supply below chosen threshold
  assign lvd_low_now = lvd_ctrl.lvd_threshold_select ? below_high_s : below_low_s;

  // Reset sequencer: holds reset while the supply is below its release threshold
  typedef enum logic [1:0] {
    SVL_RS_RUN,
    SVL_RS_POR_HOLD,
    SVL_RS_LVD_HOLD,
    SVL_RS_PULSE
  } svl_rs_state_t;

  svl_rs_state_t rs_q;                                   // Reset state
  logic          any_cause;                              // Any digital reset cause
  logic          lvd_trip;                               // Low voltage that resets the part

  assign any_cause = |rst_cause;
  assign lvd_trip  = lvd_active_q && lvd_ctrl.lvd_reset_enable && lvd_low_now;

  // Priority: power-on, then low voltage, then other causes
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rs_q <= SVL_RS_POR_HOLD;
    end else if (ce) begin
      case (rs_q)
        SVL_RS_RUN: begin
          if (por_s) begin
            rs_q <= SVL_RS_POR_HOLD;
          end else if (lvd_trip) begin
            rs_q <= SVL_RS_LVD_HOLD;
          end else if (any_cause) begin
            rs_q <= SVL_RS_PULSE;
          end
        end
        SVL_RS_POR_HOLD: begin
          if (!por_s && !below_low_s) begin
            rs_q <= SVL_RS_RUN;
          end
        end
        SVL_RS_LVD_HOLD: begin
          if (por_s) begin
            rs_q <= SVL_RS_POR_HOLD;
          end else if (!lvd_low_now) begin
            rs_q <= SVL_RS_RUN;
          end
        end
        default: begin
          rs_q <= SVL_RS_RUN;                            // One-cycle digital reset
        end
      endcase
    end
  end

  // Reset output follows the sequencer so the CPU fetches the reset vector on release
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sys_reset_q <= 1'b1;
    end else if (ce) begin
      sys_reset_q <= (rs_q != SVL_RS_RUN);
    end
  end

  // Reset-source register: written on entry to a reset from run, holds otherwise
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reset_source_register_q <= svl_pkg::RSR_RESET_VAL;
    end else if (ce && rs_q == SVL_RS_RUN) begin
      if (por_s) begin
        reset_source_register_q <= svl_pkg::RSR_RESET_VAL;
      end else if (lvd_trip) begin
        reset_source_register_q <= 8'h00;
        reset_source_register_q[svl_pkg::RSR_LVD] <= 1'b1;
      end else if (any_cause) begin
        // Debugger-forced reset leaves every bit clear
        reset_source_register_q <= 8'h00;
        reset_source_register_q[svl_pkg::RSR_PIN]  <= rst_cause.ext_pin;
        reset_source_register_q[svl_pkg::RSR_WDOG] <= rst_cause.watchdog;
        reset_source_register_q[svl_pkg::RSR_OPC]  <= rst_cause.bad_opcode;
        reset_source_register_q[svl_pkg::RSR_ADR]  <= rst_cause.bad_address;
        reset_source_register_q[svl_pkg::RSR_LOC]  <= rst_cause.clock_loss;
      end
    end
  end

  // Warning flag: set wins over a same-cycle clear so no warning is lost
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lvw_flag_q <= 1'b0;
    end else if (ce) begin
      if (sys_reset_q) begin
        lvw_flag_q <= 1'b0;                              // Part in reset drops the warning
      end else if (lvd_active_q && warn_s) begin
        lvw_flag_q <= 1'b1;
      end else if (lvw_flag_clr) begin
        lvw_flag_q <= 1'b0;
      end
    end
  end

  // Gated requests; own warning source drives vector 3
  logic [NVEC-1:0] req;                                  // Enabled pending requests
  always_comb begin
    req = src_flag & src_int_enable;
    req[svl_pkg::VEC_LVW] = lvw_flag_q && lvd_ctrl.lvw_int_enable;
    req[svl_pkg::VEC_RESET] = 1'b0;                      // Reset is not an interrupt
  end

  // Lowest vector number wins; scanning downward lets lower hits override
  logic [4:0] win_num;                                   // Winning vector
  logic       win_any;                                   // Any request pending
  always_comb begin
    win_num = 5'h00;
    win_any = 1'b0;
    for (int i = NVEC - 1; i >= 1; i--) begin
      if (req[i]) begin
        win_num = 5'(i);
        win_any = 1'b1;
      end
    end
  end

  // Vector capture: reset overrides, otherwise latch the winner at fetch
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      vec_num_q  <= svl_pkg::VEC_RESET;
      vec_addr_q <= svl_pkg::VEC_TOP_ADDR;
    end else if (ce) begin
      if (rs_q != SVL_RS_RUN) begin
        vec_num_q  <= svl_pkg::VEC_RESET;
        vec_addr_q <= svl_pkg::VEC_TOP_ADDR;
      end else if (vec_fetch) begin
        // The CPU masks itself before fetching, so the winner is stable here
        vec_num_q  <= win_num;
        vec_addr_q <= svl_pkg::VEC_TOP_ADDR - {10'h000, win_num, 1'b0};
      end
    end
  end

  // Interrupt line to the CPU, quiet while in reset
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cpu_irq_q <= 1'b0;
    end else if (ce) begin
      cpu_irq_q <= win_any && (rs_q == SVL_RS_RUN);
    end
  end

  // Clock-out divider
  logic clk_div;                                         // Divided bus clock
  svl_clkdiv #(
    .SEL_W (SEL_W),
    .CNT_W (svl_pkg::CLKOUT_CNT_W)
  ) u_div (
    .sys_clk (sys_clk),
    .rst     (rst),
    .ce      (ce),
    .sel     (clkout_select),
    .clk_div (clk_div)
  );

  // Pin mux: clock-out overrides the port direction bit
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      shared_port_pin_o_q    <= 1'b0;
      shared_port_pin_oe_n_q <= 1'b1;
    end else if (ce) begin
      if (clkout_select != '0) begin
        shared_port_pin_o_q    <= clk_div;
        shared_port_pin_oe_n_q <= 1'b0;
      end else begin
        shared_port_pin_o_q    <= port_out;
        shared_port_pin_oe_n_q <= !port_dir_out;
      end
    end
  end

  // Checks
  stop_shallow_a: assert property (@(posedge sys_clk) disable iff (rst)
    ce && stop_req == svl_pkg::SVL_STOP_DEEP && lvd_ctrl.lvd_enable && lvd_ctrl.lvd_stop_enable
    |=> stop_mode_q == svl_pkg::SVL_STOP_SHALLOW) else $error("deep stop granted with detector held");

  lvd_stop_off_a: assert property (@(posedge sys_clk) disable iff (rst)
    ce && stop_req != svl_pkg::SVL_RUN && !lvd_ctrl.lvd_stop_enable |=> !lvd_active_q)
    else $error("detector left on in stop");

  lvd_enable_a: assert property (@(posedge sys_clk) disable iff (rst)
    lvd_active_q && $past(ce) |-> $past(lvd_ctrl.lvd_enable)) else $error("detector on without enable");

  vec_addr_a: assert property (@(posedge sys_clk) disable iff (rst)
    ce && rs_q == SVL_RS_RUN && vec_fetch && req[svl_pkg::VEC_LVW] && req[2:1] == '0
    |=> vec_addr_q == 16'hfff8) else $error("warning vector address wrong");

  reset_vec_a: assert property (@(posedge sys_clk) disable iff (rst)
    ce && rs_q != SVL_RS_RUN |=> vec_addr_q == 16'hfffe && vec_num_q == 5'h00)
    else $error("reset vector not presented");

  irq_gate_a: assert property (@(posedge sys_clk) disable iff (rst)
    ce && (src_flag & src_int_enable & 32'hfffffff6) == '0 && !lvw_flag_q |=> !cpu_irq_q)
    else $error("request raised with no enabled flag");

  por_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    rs_q == SVL_RS_POR_HOLD && below_low_s |=> rs_q == SVL_RS_POR_HOLD ##1 sys_reset_q)
    else $error("released reset while supply low");

  lvw_set_a: assert property (@(posedge sys_clk) disable iff (rst)
    ce && !sys_reset_q && lvd_active_q && warn_s |=> lvw_flag_q)
    else $error("warning flag not set");

  clkout_pin_a: assert property (@(posedge sys_clk) disable iff (rst)
    ce && clkout_select != '0 |=> !shared_port_pin_oe_n_q) else $error("clock out not driven");

  lvd_no_reset_a: assert property (@(posedge sys_clk) disable iff (rst)
    ce && rs_q == SVL_RS_RUN && !lvd_ctrl.lvd_reset_enable && !por_s && !any_cause
    |=> rs_q == SVL_RS_RUN) else $error("reset without cause");

endmodule
`default_nettype wire
